// [core/ecpp_pkg.sv]
/*
 * Constants and carrier types for the extended-capabilities parallel port
 * register set and shared FIFO.
 * Assumes a single 100 MHz clock domain and an I/O-port style register bus.
 */
package ecpp_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [10:0] ECPP_OFS_DATA = 11'h000;
  localparam logic [10:0] ECPP_OFS_STATUS = 11'h001;
  localparam logic [10:0] ECPP_OFS_CONTROL = 11'h002;
  localparam logic [10:0] ECPP_OFS_FIFO = 11'h400;
  localparam logic [10:0] ECPP_OFS_CFGB = 11'h401;
  localparam logic [10:0] ECPP_OFS_ECR = 11'h402;

  // ----------------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------------
  localparam logic [2:0] ECPP_MODE_SPP = 3'h0;
  localparam logic [2:0] ECPP_MODE_PS2 = 3'h1;
  localparam logic [2:0] ECPP_MODE_COMPAT_FIFO_PORT = 3'h2;
  localparam logic [2:0] ECPP_MODE_ECP = 3'h3;
  localparam logic [2:0] ECPP_MODE_EPP = 3'h4;
  localparam logic [2:0] ECPP_MODE_TEST = 3'h6;
  localparam logic [2:0] ECPP_MODE_CFG = 3'h7;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int ECPP_CTL_DIR = 5;
  localparam int ECPP_CTL_ACKINT = 4;
  localparam int ECPP_CTL_SELIN = 3;
  localparam int ECPP_CTL_INIT = 2;
  localparam int ECPP_CTL_AFD = 1;
  localparam int ECPP_CTL_STB = 0;
  localparam int ECPP_ECR_MODE_LSB = 5;
  localparam int ECPP_ECR_FAULT_DIS = 4;
  localparam int ECPP_ECR_DMA_EN = 3;
  localparam int ECPP_ECR_SERV = 2;

  // ----------------------------------------------------------------------
  // Reset and fixed values
  // ----------------------------------------------------------------------
  localparam logic [5:0] ECPP_CTL_RST = 6'h00;
  localparam logic [7:0] ECPP_DATA_RST = 8'h00;
  localparam logic [2:0] ECPP_MODE_RST = 3'h0;
  localparam logic ECPP_FAULT_DIS_RST = 1'b0;
  localparam logic ECPP_DMA_EN_RST = 1'b0;
  localparam logic ECPP_SERV_RST = 1'b0;
  localparam logic [2:0] ECPP_CFGB_LOW_RST = 3'h7;
  localparam logic [7:0] ECPP_CFGA_VALUE = 8'h10;
  localparam logic [1:0] ECPP_CTL_TOP_ONES = 2'h3;
  localparam logic [2:0] ECPP_STATUS_LOW_ONES = 3'h7;
  localparam int ECPP_FIFO_DEPTH = 16;
  localparam int ECPP_WR_THRESH = 8;
  localparam int ECPP_RD_THRESH = 8;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic busy;
    logic nack;
    logic perror;
    logic select;
    logic nfault;
  } ecpp_pins_in_t;

  typedef struct packed {
    logic nstrobe;
    logic nautofd;
    logic ninit;
    logic nselectin;
  } ecpp_lines_out_t;

  typedef enum logic [2:0] {
    ECPP_HS_IDLE,
    ECPP_HS_SETUP,
    ECPP_HS_STROBE,
    ECPP_HS_DONE,
    ECPP_HS_REV_WAIT,
    ECPP_HS_REV_ACK
  } ecpp_hs_t;

endpackage : ecpp_pkg

// [core/ecpp_port_core.sv]
/*
 * Register set, shared FIFO and automatic line handshake of a host-side
 * extended-capabilities parallel port.
 * Assumes one-cycle IOR/IOW strobes on MCLK, DACK qualifying DMA cycles,
 * and asynchronous peripheral pins that are synchronised here.
 */
//
// Contract
// RULE1: Status reads inverted busy and lines, ones
// RULE2: Control top two bits read one
// RULE3: Direction ignored, output in 000/010
// RULE4: Ack rising edge interrupts when enabled
// RULE5: Control bits drive strobe, autofeed, init, select
// RULE6: Mode 010 sends FIFO bytes forward
// RULE7: Mode 011 sends or captures per direction
// RULE8: Test mode FIFO access, nothing sent
// RULE9: Config A reads 10H in mode 111
// RULE10: Config B compression zero, low three writable
// RULE11: Config B bit six shows IRQ level
// RULE12: Config B bits five-three report IRQ
// RULE13: ECR top bits select mode; 000 resets
// RULE14: Mode 001 tri-states, data reads pins
// RULE15: Address and data ports share FIFO order
// RULE16: Mode 111 maps config registers
// RULE17: ECP nFault falling edge interrupts unless disabled
// RULE18: DMA enable bit gates DMA requests
// RULE19: Service bit set by events, blocks
// RULE20: Service events on count or threshold
// RULE21: FIFO full and empty flags readable
// RULE22: One common sixteen-byte FIFO
// RULE23: Software switches modes via 000/001 only
// RULE24: FIFO disabled after reset
// RULE25: HostAck high data, low command
// RULE26: Flags from occupancy count updated per cycle
`timescale 1ns/10ps

module ecpp_port_core import ecpp_pkg::*; #(
  parameter int DEPTH = ECPP_FIFO_DEPTH,
  parameter int WR_THRESH = ECPP_WR_THRESH,
  parameter int RD_THRESH = ECPP_RD_THRESH
) (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic [10:0] ADDR,
  input wire logic IOR,
  input wire logic IOW,
  input wire logic [7:0] DIN,
  output logic [7:0] DOUT,
  input wire logic DACK,
  input wire logic TC,
  output logic DRQ,
  output logic IRQ,
  input wire logic [2:0] IRQ_SEL,
  input wire logic IRQ_LEVEL,
  input wire ecpp_pins_in_t PINS_IN,
  input wire logic [7:0] PD_I,
  output logic [7:0] PD_O,
  output logic PD_OE,
  output ecpp_lines_out_t LINES_OUT
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    ecpp_pins_in_t pin1;
    ecpp_pins_in_t pin2;
    ecpp_pins_in_t pin3;
    logic [7:0] pd1;
    logic [7:0] pd2;
    logic lvl1;
    logic lvl2;
    logic [7:0] data;
    logic [5:0] ctl;
    logic [2:0] mode;
    logic fault_dis;
    logic dma_en;
    logic serv;
    logic [2:0] cfgb_low;
    logic [DEPTH-1:0][8:0] mem;
    logic [AW-1:0] rd_ptr;
    logic [AW-1:0] wr_ptr;
    logic [CW-1:0] cnt;
    ecpp_hs_t hs;
    logic [7:0] pd_out;
    logic nstb;
    logic hack;
    logic [7:0] dout;
    logic irq;
  } ecpp_state_t;

  ecpp_state_t st_q;
  ecpp_state_t st_d;
  logic rst_s1_q;
  logic rst_s2_q;

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // ----------------------------------------------------------------------
  // Decoded mode terms
  // ----------------------------------------------------------------------
  logic dir;
  logic fwd_mode;
  logic rev_mode;
  logic fifo_mode;
  logic full;
  logic empty;
  logic [CW-1:0] free_cnt;

  assign dir = st_q.ctl[ECPP_CTL_DIR];
  // Compat FIFO mode is forward only, so direction is ignored there
  assign fwd_mode = (st_q.mode == ECPP_MODE_COMPAT_FIFO_PORT) ||
                    (st_q.mode == ECPP_MODE_ECP && !dir); // RULE6 RULE7
  assign rev_mode = (st_q.mode == ECPP_MODE_ECP) && dir; // RULE7
  assign fifo_mode = fwd_mode || rev_mode || (st_q.mode == ECPP_MODE_TEST);
  assign full = (st_q.cnt == CW'(DEPTH)); // RULE21 RULE26
  assign empty = (st_q.cnt == '0); // RULE21 RULE26
  assign free_cnt = CW'(DEPTH) - st_q.cnt;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic dma_cyc;
    logic fifo_wr;
    logic fifo_rd;
    logic afifo_wr;
    logic push;
    logic pop;
    logic [8:0] push_word;
    logic svc_evt;
    logic dir_eff;
    dma_cyc = DACK && (IOR || IOW);
    fifo_wr = 1'b0;
    fifo_rd = 1'b0;
    afifo_wr = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    push_word = '0;
    svc_evt = 1'b0;
    dir_eff = (st_q.mode == ECPP_MODE_COMPAT_FIFO_PORT) ? 1'b0 : dir;
    st_d = st_q;
    st_d.irq = 1'b0;

    // Pin synchronisers; only stage two onward is looked at
    st_d.pin1 = PINS_IN;
    st_d.pin2 = st_q.pin1;
    st_d.pin3 = st_q.pin2;
    st_d.pd1 = PD_I;
    st_d.pd2 = st_q.pd1;
    st_d.lvl1 = IRQ_LEVEL;
    st_d.lvl2 = st_q.lvl1;

    // Host and DMA FIFO port access; DMA always targets the data FIFO
    if (IOW && (DACK || ADDR == ECPP_OFS_FIFO)) begin
      fifo_wr = fwd_mode || (st_q.mode == ECPP_MODE_TEST); // RULE6 RULE8
    end
    if (IOR && (DACK || ADDR == ECPP_OFS_FIFO)) begin
      fifo_rd = rev_mode || (st_q.mode == ECPP_MODE_TEST); // RULE7 RULE8
    end
    afifo_wr = IOW && !DACK && ADDR == ECPP_OFS_DATA &&
               st_q.mode == ECPP_MODE_ECP && !dir; // RULE15

    if (fifo_wr || afifo_wr) begin
      push = 1'b1;
      push_word = {afifo_wr, DIN}; // RULE15
    end
    if (fifo_rd) begin
      pop = 1'b1;
    end

    // Register writes
    if (IOW && !DACK) begin
      unique case (ADDR)
        ECPP_OFS_DATA: begin
          if (st_q.mode == ECPP_MODE_SPP || st_q.mode == ECPP_MODE_PS2) begin
            st_d.data = DIN;
          end
        end
        ECPP_OFS_CONTROL: begin
          st_d.ctl = DIN[5:0]; // RULE2
        end
        ECPP_OFS_CFGB: begin
          if (st_q.mode == ECPP_MODE_CFG) begin
            st_d.cfgb_low = DIN[2:0]; // RULE10
          end
        end
        ECPP_OFS_ECR: begin
          st_d.mode = DIN[ECPP_ECR_MODE_LSB +: 3]; // RULE13
          st_d.fault_dis = DIN[ECPP_ECR_FAULT_DIS]; // RULE17
          st_d.dma_en = DIN[ECPP_ECR_DMA_EN]; // RULE18
          st_d.serv = DIN[ECPP_ECR_SERV]; // RULE19
        end
        default: begin
        end
      endcase
    end

    // Line handshake
    unique case (st_q.hs)
      ECPP_HS_IDLE: begin
        st_d.nstb = 1'b1;
        if (fwd_mode && !empty && !st_q.pin2.busy) begin
          st_d.pd_out = st_q.mem[st_q.rd_ptr][7:0]; // RULE6 RULE7
          // Commands leave with HostAck low, data with it high
          st_d.hack = !st_q.mem[st_q.rd_ptr][8]; // RULE25
          pop = 1'b1;
          st_d.hs = ECPP_HS_SETUP;
        end else if (rev_mode) begin
          st_d.hack = 1'b0;
          st_d.hs = ECPP_HS_REV_WAIT;
        end else begin
          st_d.hack = 1'b1;
        end
      end
      ECPP_HS_SETUP: begin
        // One cycle of data setup before the strobe falls
        st_d.nstb = 1'b0;
        st_d.hs = ECPP_HS_STROBE;
      end
      ECPP_HS_STROBE: begin
        if (st_q.pin2.busy) begin
          st_d.nstb = 1'b1;
          st_d.hs = ECPP_HS_DONE;
        end
      end
      ECPP_HS_DONE: begin
        if (!st_q.pin2.busy) begin
          st_d.hack = 1'b1;
          st_d.hs = ECPP_HS_IDLE;
        end
      end
      ECPP_HS_REV_WAIT: begin
        if (!rev_mode) begin
          st_d.hack = 1'b1;
          st_d.hs = ECPP_HS_IDLE;
        end else if (!st_q.pin2.nack && !full) begin
          // Capture while PeriphClk is low; busy low tags a command
          push = 1'b1;
          push_word = {!st_q.pin2.busy, st_q.pd2}; // RULE7
          st_d.hack = 1'b1;
          st_d.hs = ECPP_HS_REV_ACK;
        end
      end
      ECPP_HS_REV_ACK: begin
        if (st_q.pin2.nack) begin
          st_d.hack = 1'b0;
          st_d.hs = ECPP_HS_REV_WAIT;
        end
      end
    endcase

    // Shared FIFO, one push and one pop per cycle at most
    push = push && !full;
    pop = pop && !empty;
    if (push) begin
      st_d.mem[st_q.wr_ptr] = push_word; // RULE22
      st_d.wr_ptr = st_q.wr_ptr + AW'(1);
    end
    if (pop) begin
      st_d.rd_ptr = st_q.rd_ptr + AW'(1);
    end
    st_d.cnt = st_q.cnt + CW'(push) - CW'(pop); // RULE26

    // Standard mode holds the FIFO cleared, which also covers reset
    if (st_q.mode == ECPP_MODE_SPP) begin
      st_d.rd_ptr = '0; // RULE13 RULE24
      st_d.wr_ptr = '0;
      st_d.cnt = '0;
      st_d.hs = ECPP_HS_IDLE;
      st_d.nstb = 1'b1;
      st_d.hack = 1'b1;
    end

    // Service events; set wins over a same-cycle software clear
    if (!st_q.serv && fifo_mode) begin
      if (st_q.dma_en) begin
        svc_evt = dma_cyc && TC; // RULE20
      end else if (!dir_eff) begin
        svc_evt = free_cnt >= CW'(WR_THRESH); // RULE20
      end else begin
        svc_evt = st_q.cnt >= CW'(RD_THRESH); // RULE20
      end
    end
    if (svc_evt) begin
      st_d.serv = 1'b1; // RULE19
    end

    // Interrupt pulses
    if (svc_evt) begin
      st_d.irq = 1'b1; // RULE19
    end
    if (st_q.ctl[ECPP_CTL_ACKINT] && st_q.pin2.nack && !st_q.pin3.nack) begin
      st_d.irq = 1'b1; // RULE4
    end
    if (st_q.mode == ECPP_MODE_ECP && !st_q.fault_dis &&
        !st_q.pin2.nfault && st_q.pin3.nfault) begin
      st_d.irq = 1'b1; // RULE17
    end

    // Read data
    if (IOR) begin
      st_d.dout = 8'h00;
      if (fifo_rd) begin
        st_d.dout = st_q.mem[st_q.rd_ptr][7:0];
      end else if (!DACK) begin
        unique case (ADDR)
          ECPP_OFS_DATA: begin
            // PS/2 mode reads the pins, standard mode the latch
            st_d.dout = (st_q.mode == ECPP_MODE_PS2) ? st_q.pd2 :
                        st_q.data; // RULE14
          end
          ECPP_OFS_STATUS: begin
            st_d.dout = {!st_q.pin2.busy, st_q.pin2.nack,
                         st_q.pin2.perror, st_q.pin2.select,
                         st_q.pin2.nfault, ECPP_STATUS_LOW_ONES}; // RULE1
          end
          ECPP_OFS_CONTROL: begin
            st_d.dout = {ECPP_CTL_TOP_ONES, st_q.ctl}; // RULE2
          end
          ECPP_OFS_FIFO: begin
            if (st_q.mode == ECPP_MODE_CFG) begin
              st_d.dout = ECPP_CFGA_VALUE; // RULE9 RULE16
            end
          end
          ECPP_OFS_CFGB: begin
            if (st_q.mode == ECPP_MODE_CFG) begin
              st_d.dout = {1'b0, st_q.lvl2, IRQ_SEL,
                           st_q.cfgb_low}; // RULE10 RULE11 RULE12 RULE16
            end
          end
          ECPP_OFS_ECR: begin
            st_d.dout = {st_q.mode, st_q.fault_dis, st_q.dma_en,
                         st_q.serv, full, empty}; // RULE21
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      st_q <= '0;
      st_q.pin1 <= '1;
      st_q.pin2 <= '1;
      st_q.pin3 <= '1;
      st_q.data <= ECPP_DATA_RST;
      st_q.ctl <= ECPP_CTL_RST;
      st_q.mode <= ECPP_MODE_RST; // RULE24
      st_q.fault_dis <= ECPP_FAULT_DIS_RST;
      st_q.dma_en <= ECPP_DMA_EN_RST;
      st_q.serv <= ECPP_SERV_RST;
      st_q.cfgb_low <= ECPP_CFGB_LOW_RST;
      st_q.hs <= ECPP_HS_IDLE;
      st_q.nstb <= 1'b1;
      st_q.hack <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Requests stop while the service bit is set; software re-arms it
  assign DRQ = st_q.dma_en && !st_q.serv && fifo_mode &&
               (st_q.ctl[ECPP_CTL_DIR] && st_q.mode != ECPP_MODE_COMPAT_FIFO_PORT ?
                !empty : !full); // RULE18 RULE19
  assign IRQ = st_q.irq;
  assign DOUT = st_q.dout;

  always_comb begin
    if (fwd_mode) begin
      PD_O = st_q.pd_out;
    end else if (st_q.mode == ECPP_MODE_TEST) begin
      PD_O = st_q.mem[st_q.rd_ptr][7:0]; // RULE8
    end else begin
      PD_O = st_q.data;
    end
  end

  assign PD_OE = (st_q.mode == ECPP_MODE_SPP ||
                  st_q.mode == ECPP_MODE_COMPAT_FIFO_PORT) ? 1'b1 : !dir; // RULE3 RULE14

  assign LINES_OUT.nstrobe = fwd_mode ? st_q.nstb :
                             !st_q.ctl[ECPP_CTL_STB]; // RULE5
  assign LINES_OUT.nautofd = (st_q.mode == ECPP_MODE_ECP) ? st_q.hack :
                             !st_q.ctl[ECPP_CTL_AFD]; // RULE5 RULE25
  assign LINES_OUT.ninit = st_q.ctl[ECPP_CTL_INIT]; // RULE5
  assign LINES_OUT.nselectin = !st_q.ctl[ECPP_CTL_SELIN]; // RULE5

endmodule : ecpp_port_core

// [test/ecpp_printer_model.sv]
/* Behavioural printer on the forward lines of the port.
   Assumes the shared MCLK; takes each strobed byte, answers with busy. */
`timescale 1ns/10ps
module ecpp_printer_model (
  input wire logic clk,
  input wire logic [7:0] dly,
  input wire logic nstrobe,
  input wire logic nautofd,
  input wire logic [7:0] pd,
  output logic busy,
  output logic [7:0] last_byte,
  output logic last_cmd,
  output int got
);
  // ------------------------------------------------------------
  // Byte capture and busy answer
  // ------------------------------------------------------------
  initial begin
    busy = 1'b0;
    last_byte = 8'h00;
    last_cmd = 1'b0;
    got = 0;
    forever begin
      @(posedge clk);
      if (nstrobe === 1'b0) begin
        last_byte = pd;
        last_cmd = !nautofd;
        got++;
        // Slow answer keeps the host strobe low for a while
        repeat (dly) @(posedge clk);
        busy <= 1'b1;
        while (nstrobe !== 1'b1) @(posedge clk);
        repeat (dly) @(posedge clk);
        busy <= 1'b0;
      end
    end
  end
endmodule : ecpp_printer_model

// [test/ecpp_port_core_properties.sv]
/* Checker for the port core: reads, line outputs, DMA gating.
   Assumes host writes never collide with DMA cycles. */
`timescale 1ns/10ps
module ecpp_port_core_properties import ecpp_pkg::*; (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic [10:0] ADDR,
  input wire logic IOR,
  input wire logic IOW,
  input wire logic [7:0] DIN,
  input wire logic [7:0] DOUT,
  input wire logic DACK,
  input wire logic TC,
  input wire logic DRQ,
  input wire logic [2:0] IRQ_SEL,
  input wire logic PD_OE,
  input wire ecpp_lines_out_t LINES_OUT
);
  // ------------------------------------------------------------
  // Shadow of host writes
  // ------------------------------------------------------------
  logic [2:0] mode_q;
  logic [5:0] ctl_q;
  logic dma_q;
  logic hr;
  logic hw;
  logic fwd;
  assign hr = IOR && !DACK;
  assign hw = IOW && !DACK;
  assign fwd = mode_q == ECPP_MODE_COMPAT_FIFO_PORT || mode_q == ECPP_MODE_ECP;
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      mode_q <= 3'h0;
      ctl_q <= 6'h00;
      dma_q <= 1'b0;
    end else begin
      if (hw && ADDR == ECPP_OFS_ECR) begin
        mode_q <= DIN[7:5];
        dma_q <= DIN[3];
      end
      if (hw && ADDR == ECPP_OFS_CONTROL) begin
        ctl_q <= DIN[5:0];
      end
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  sequence s_fwd_strobe;
    fwd && $fell(LINES_OUT.nstrobe);
  endsequence
  a_ctl_drives_lines:
    assert property (mode_q == ECPP_MODE_SPP |-> LINES_OUT ==
      {!ctl_q[0], !ctl_q[1], ctl_q[2], !ctl_q[3]}) else $error("lines");
  a_out_forced:
    assert property (mode_q == ECPP_MODE_SPP || mode_q == ECPP_MODE_COMPAT_FIFO_PORT
      |-> PD_OE) else $error("data not driven");
  a_ps2_float:
    assert property (mode_q == ECPP_MODE_PS2 && ctl_q[5] |-> !PD_OE)
    else $error("data driven in input mode");
  a_status_ones:
    assert property (hr && ADDR == ECPP_OFS_STATUS |=> DOUT[2:0] == 3'h7)
    else $error("status low bits");
  a_ctl_read:
    assert property (hr && ADDR == ECPP_OFS_CONTROL |=>
      DOUT == {2'h3, $past(ctl_q)}) else $error("control read");
  a_cfga_fixed:
    assert property (hr && ADDR == ECPP_OFS_FIFO && mode_q == ECPP_MODE_CFG
      |=> DOUT == ECPP_CFGA_VALUE) else $error("config A read");
  a_cfgb_bits:
    assert property (hr && ADDR == ECPP_OFS_CFGB && mode_q == ECPP_MODE_CFG
      |=> !DOUT[7] && DOUT[5:3] == $past(IRQ_SEL)) else $error("config B");
  a_mode_read:
    assert property (hr && ADDR == ECPP_OFS_ECR |=> DOUT[7:5] ==
      $past(mode_q) && ($past(mode_q) != ECPP_MODE_SPP || DOUT[1:0] == 2'h1))
    else $error("mode read");
  a_dma_gate:
    assert property (!dma_q |-> !DRQ) else $error("request without enable");
  a_tc_ends_drq:
    assert property (DACK && (IOR || IOW) && TC && dma_q |=> !DRQ)
    else $error("request after count");
  a_fwd_strobe:
    assert property (s_fwd_strobe |=> !LINES_OUT.nstrobe [*2]
      ##[1:60] LINES_OUT.nstrobe) else $error("strobe handshake");
endmodule : ecpp_port_core_properties

bind ecpp_port_core ecpp_port_core_properties i_ecpp_port_core_properties (
  .MCLK(MCLK), .RST_B(RST_B), .ADDR(ADDR), .IOR(IOR), .IOW(IOW),
  .DIN(DIN), .DOUT(DOUT), .DACK(DACK), .TC(TC), .DRQ(DRQ),
  .IRQ_SEL(IRQ_SEL), .PD_OE(PD_OE), .LINES_OUT(LINES_OUT));

// [test/tb_ecpp_port_core.sv]
/* Self-checking bench for the port core with a printer model.
   Assumes the package constants and a 100 MHz MCLK. */
`timescale 1ns/10ps
module tb_ecpp_port_core import ecpp_pkg::*;;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic mclk, rst_b, ior, iow, dack, tc, irq_lvl, bsy_f, nack, perr, sel;
  logic nflt, drq, irq, pd_oe, busy_m, lcmd;
  logic [10:0] addr;
  logic [7:0] din, dout, pd_i, pd_o, pd_ext, lbyte, dly;
  logic [2:0] irq_sel;
  ecpp_lines_out_t lines;
  ecpp_pins_in_t pins;
  int err_count, tests_run, cyc, got, g0;
  assign pins = {busy_m | bsy_f, nack, perr, sel, nflt};
  assign pd_i = pd_oe ? pd_o : pd_ext;
  always #5 mclk = ~mclk;
  ecpp_port_core i_ecpp_port_core (.MCLK(mclk), .RST_B(rst_b), .ADDR(addr),
    .IOR(ior), .IOW(iow), .DIN(din), .DOUT(dout), .DACK(dack), .TC(tc),
    .DRQ(drq), .IRQ(irq), .IRQ_SEL(irq_sel), .IRQ_LEVEL(irq_lvl),
    .PINS_IN(pins), .PD_I(pd_i), .PD_O(pd_o), .PD_OE(pd_oe),
    .LINES_OUT(lines));
  ecpp_printer_model i_ecpp_printer_model (.clk(mclk), .dly(dly),
    .nstrobe(lines.nstrobe), .nautofd(lines.nautofd), .pd(pd_o),
    .busy(busy_m), .last_byte(lbyte), .last_cmd(lcmd), .got(got));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t saw %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(negedge mclk);
    {addr, din, iow} = {a, d, 1'b1};
    @(negedge mclk);
    iow = 1'b0;
  endtask : wr
  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    @(negedge mclk);
    {addr, ior} = {a, 1'b1};
    @(negedge mclk);
    ior = 1'b0;
    chk(dout, e);
  endtask : rd
  task automatic dw(input logic [7:0] d, input logic t);
    @(negedge mclk);
    {dack, iow, din, tc} = {2'h3, d, t};
    @(negedge mclk);
    {dack, iow, tc} = 3'h0;
  endtask : dw
  // Pulse is one cycle wide, so every cycle is looked at
  task automatic irq_seen(input logic e);
    logic s;
    s = 1'b0;
    repeat (8) begin
      s = s | (irq === 1'b1);
      @(negedge mclk);
    end
    chk({7'h0, s}, {7'h0, e});
  endtask : irq_seen
  task automatic sent(input int n, input logic [7:0] b, input logic c);
    for (int k = 0; k < 200 && got < n; k++) @(negedge mclk);
    chk(lbyte, b);
    chk({7'h0, lcmd}, {7'h0, c});
  endtask : sent
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("[FAIL] %0t run too long", $time);
      test_done;
    end
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    {mclk, rst_b, ior, iow, dack, tc, bsy_f, perr, irq_lvl} = '0;
    {nack, sel, nflt} = 3'h7;
    {addr, din, pd_ext, irq_sel} = '0;
    {err_count, tests_run, cyc, g0} = '0;
    dly = 8'h01;
    repeat (6) @(negedge mclk);
    rst_b = 1'b1;
    repeat (3) @(negedge mclk);
    rd(ECPP_OFS_STATUS, 8'hdf);
    rd(ECPP_OFS_CONTROL, 8'hc0);
    rd(ECPP_OFS_ECR, 8'h01);
    bsy_f = 1'b1;
    repeat (4) @(negedge mclk);
    rd(ECPP_OFS_STATUS, 8'h5f);
    bsy_f = 1'b0;
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      wr(ECPP_OFS_CONTROL, 8'hf0 | i[7:0]);
      chk({4'h0, lines}, {4'h0, ~i[0], ~i[1], i[2], ~i[3]});
      chk({7'h0, pd_oe}, 8'h01);
    end
    rd(ECPP_OFS_CONTROL, 8'hff);
    nack = 1'b0;
    repeat (4) @(negedge mclk);
    nack = 1'b1;
    irq_seen(1'b1);
    wr(ECPP_OFS_CONTROL, 8'h00);
    nack = 1'b0;
    repeat (4) @(negedge mclk);
    nack = 1'b1;
    irq_seen(1'b0);
    $display("test control done");
    wr(ECPP_OFS_ECR, 8'h20);
    wr(ECPP_OFS_CONTROL, 8'h20);
    pd_ext = 8'ha5;
    repeat (3) @(negedge mclk);
    chk({7'h0, pd_oe}, 8'h00);
    rd(ECPP_OFS_DATA, 8'ha5);
    wr(ECPP_OFS_ECR, 8'h40);
    chk({7'h0, pd_oe}, 8'h01);
    wr(ECPP_OFS_ECR, 8'h00);
    wr(ECPP_OFS_ECR, 8'h20);
    wr(ECPP_OFS_CONTROL, 8'h00);
    wr(ECPP_OFS_ECR, 8'h00);
    wr(ECPP_OFS_DATA, 8'h3c);
    chk(pd_o, 8'h3c);
    $display("test direction done");
    dly = 8'h0c;
    bsy_f = 1'b1;
    wr(ECPP_OFS_ECR, 8'h40);
    g0 = got;
    for (int i = 0; i < 17; i++) wr(ECPP_OFS_FIFO, i[7:0]);
    rd(ECPP_OFS_ECR, 8'h46);
    bsy_f = 1'b0;
    for (int i = 0; i < 16; i++) sent(g0 + i + 1, i[7:0], 1'b0);
    repeat (60) @(negedge mclk);
    chk(8'(got - g0), 8'h10);
    rd(ECPP_OFS_ECR, 8'h45);
    wr(ECPP_OFS_ECR, 8'h44);
    irq_seen(1'b0);
    wr(ECPP_OFS_ECR, 8'h40);
    irq_seen(1'b1);
    $display("test parallel fifo done");
    wr(ECPP_OFS_ECR, 8'h00);
    dly = 8'h01;
    bsy_f = 1'b1;
    wr(ECPP_OFS_ECR, 8'h60);
    g0 = got;
    wr(ECPP_OFS_DATA, 8'h81);
    wr(ECPP_OFS_FIFO, 8'h22);
    bsy_f = 1'b0;
    sent(g0 + 1, 8'h81, 1'b1);
    sent(g0 + 2, 8'h22, 1'b0);
    wr(ECPP_OFS_ECR, 8'h64);
    nflt = 1'b0;
    irq_seen(1'b1);
    nflt = 1'b1;
    wr(ECPP_OFS_ECR, 8'h74);
    repeat (4) @(negedge mclk);
    nflt = 1'b0;
    irq_seen(1'b0);
    nflt = 1'b1;
    $display("test ecp done");
    wr(ECPP_OFS_ECR, 8'h20);
    wr(ECPP_OFS_CONTROL, 8'h20);
    wr(ECPP_OFS_ECR, 8'h60);
    pd_ext = 8'h5a;
    bsy_f = 1'b1;
    nack = 1'b0;
    repeat (6) @(negedge mclk);
    chk({7'h0, lines.nautofd}, 8'h01);
    nack = 1'b1;
    repeat (6) @(negedge mclk);
    chk({7'h0, lines.nautofd}, 8'h00);
    rd(ECPP_OFS_FIFO, 8'h5a);
    rd(ECPP_OFS_ECR, 8'h61);
    wr(ECPP_OFS_ECR, 8'h20);
    wr(ECPP_OFS_CONTROL, 8'h00);
    bsy_f = 1'b0;
    $display("test reverse done");
    wr(ECPP_OFS_ECR, 8'h00);
    wr(ECPP_OFS_ECR, 8'hc0);
    chk({7'h0, drq}, 8'h00);
    wr(ECPP_OFS_ECR, 8'hc8);
    chk({7'h0, drq}, 8'h01);
    g0 = got;
    dw(8'h11, 1'b0);
    dw(8'h22, 1'b0);
    dw(8'h33, 1'b1);
    irq_seen(1'b1);
    chk({7'h0, drq}, 8'h00);
    rd(ECPP_OFS_FIFO, 8'h11);
    rd(ECPP_OFS_FIFO, 8'h22);
    rd(ECPP_OFS_ECR, 8'hcc);
    chk(pd_o, 8'h33);
    chk(8'(got - g0), 8'h00);
    wr(ECPP_OFS_ECR, 8'h00);
    rd(ECPP_OFS_ECR, 8'h01);
    $display("test dma done");
    wr(ECPP_OFS_ECR, 8'he0);
    rd(ECPP_OFS_FIFO, 8'h10);
    for (int k = 0; k < 8; k++) begin
      irq_sel = k[2:0];
      irq_lvl = k[0];
      repeat (3) @(negedge mclk);
      rd(ECPP_OFS_CFGB, {1'b0, k[0], k[2:0], 3'h7});
    end
    wr(ECPP_OFS_CFGB, 8'hfa);
    rd(ECPP_OFS_CFGB, 8'h7a);
    wr(ECPP_OFS_FIFO, 8'h55);
    rd(ECPP_OFS_FIFO, 8'h10);
    rd(11'h003, 8'h00);
    wr(ECPP_OFS_ECR, 8'h00);
    $display("test config done");
    test_done;
  end
endmodule : tb_ecpp_port_core
